// ===== rtl/mcm_dev.sv
// Meter device end: command byte decoder and mode register
// Contract
// - every transfer opens with a command byte
// - command low five bits give address
// - host sends command bits five, six zero
// - command bit seven one means write
// - mode bit zero bypasses high-pass filter
// - mode bit one bypasses power low-pass
// - mode bit two disables pulse output
// - mode bit three disables dip detect
// - mode bit four powers converters down
// - bit five starts conversion, self-clears
// - bit six resets; 18 us quiet
// - bit seven selects half-cycle accumulation
// - bits eight, nine short converter inputs
// - bit ten swaps the input pairs
// - bits twelve, eleven pick waveform rate
// - bits fourteen, thirteen pick waveform source
// - host keeps bit fifteen at zero
// - mode readable, resets to 000c
`timescale 1ns/10ps
module mcm_dev
    import mcm_pkg::*;
(
    input  wire logic        clk_i,                  // Master clock
    input  wire logic        rst_i,                  // Sync reset, high
    mcm_link_if.dev          link,                   // Link to host
    input  wire logic        temp_done_i,            // Conversion finished
    output logic             bypass_highpass_o,      // Skip high-pass
    output logic             bypass_power_lowpass_o, // Skip power low-pass
    output logic             pulse_out_off_o,        // Pulse output off
    output logic             dip_detect_off_o,       // Dip detection off
    output logic             converters_powerdown_o, // Converters off
    output logic             thermal_conv_start_o,   // Conversion running
    output logic             soft_reset_o,           // Soft reset pulse
    output logic             halfcycle_accum_mode_o, // Half-cycle mode
    output logic             short_inputs_a_o,       // Short converter 1
    output logic             short_inputs_b_o,       // Short converter 2
    output logic             swap_inputs_o,          // Exchange inputs
    output logic [1:0]       wave_source_sel_o,      // Waveform source
    output logic [5:0]       wave_len_o,             // Sample length, bits
    output logic             wave_tick_o,            // Waveform update
    output logic             factory_test_bit_o,     // Test mode
    output logic [15:0]      mode_config_o           // Whole mode register
);
    import mcm_pkg::*;

    // Transfer phases
    typedef enum logic [1:0] {
        ST_CMD,   // Waiting for a command byte
        ST_WR,    // Collecting write bytes
        ST_RD     // Sending read bytes
    } mcm_dev_state_t;

    mcm_dev_state_t state,     next_state;     // Phase
    logic [4:0]     addr,      next_addr;      // Target register address
    logic [1:0]     left,      next_left;      // Bytes still to move
    logic [15:0]    shreg,     next_shreg;     // Assembled write data
    logic [15:0]    mode,      next_mode;      // Mode register
    logic [9:0]     hold,      next_hold;      // Quiet-time counter
    logic           dvld,      next_dvld;      // Read byte valid
    logic [7:0]     dbyte,     next_dbyte;     // Read byte
    logic           srst,      next_srst;      // Soft reset pulse
    logic [9:0]     wdiv,      next_wdiv;      // Waveform divider
    logic           wtick,     next_wtick;     // Waveform tick
    logic [15:0]    rd_val;                    // Value of addressed reg
    logic [15:0]    wr_val;                    // Completed write word
    logic [9:0]     wlim;                      // Divider terminal count
    logic           therm_set;                 // Write sets bit five

    // Read value of the addressed register; others read as zero
    always_comb begin
        rd_val = (addr == MODE_ADDR) ? mode : 16'h0000;
    end

    // Divider terminal count from the rate code
    always_comb begin
        wlim = 10'((WAVE_DIV_BASE << mode[MB_RATE_LSB +: 2]) - 1);
    end

    // Next-state logic for the link side and mode register
    always_comb begin
        next_state = state;
        next_addr  = addr;
        next_left  = left;
        next_shreg = shreg;
        next_mode  = mode;
        next_hold  = hold;
        next_dvld  = 1'b0;
        next_dbyte = dbyte;
        next_srst  = 1'b0;
        therm_set  = 1'b0;
        wr_val     = {shreg[7:0], link.host_byte};
        // Conversion end clears the start bit
        if (temp_done_i) begin
            next_mode[MB_THERM] = 1'b0;
        end
        if (hold != 10'd0) begin
            // Quiet time: link traffic is ignored
            next_hold  = hold - 10'd1;
            next_state = ST_CMD;
        end else begin
            unique case (state)
                ST_CMD: begin
                    // Every transfer opens with a command byte
                    if (link.host_vld) begin
                        next_addr  = link.host_byte[CMD_ADDR_LSB +:
                                                    CMD_ADDR_W];
                        next_left  = mcm_reg_bytes(next_addr);
                        next_shreg = 16'h0000;
                        // Bits five and six are not looked at
                        if (link.host_byte[CMD_WRITE_BIT]) begin
                            next_state = ST_WR;
                        end else begin
                            next_state = ST_RD;
                        end
                    end
                end
                ST_WR: begin
                    // Shift bytes in, most significant first
                    if (link.host_vld) begin
                        next_shreg = wr_val;
                        next_left  = left - 2'd1;
                        if (left == 2'd1) begin
                            next_state = ST_CMD;
                            if (addr == MODE_ADDR) begin
                                next_mode = wr_val;
                                therm_set = wr_val[MB_THERM];
                                if (wr_val[MB_SOFT_RST]) begin
                                    // Whole chip back to defaults
                                    next_mode = MODE_RESET;
                                    next_hold = 10'(HOLDOFF_CYC);
                                    next_srst = 1'b1;
                                end
                            end
                        end
                    end
                end
                ST_RD: begin
                    // Hand out one byte per request, top byte first
                    if (link.rd_req) begin
                        next_dvld  = 1'b1;
                        next_dbyte = left == 2'd2 ? rd_val[15:8]
                                                  : rd_val[7:0];
                        next_left  = left - 2'd1;
                        if (left == 2'd1) begin
                            next_state = ST_CMD;
                        end
                    end
                end
            endcase
        end
        // A start written together with a finish still starts
        if (therm_set && !next_srst) begin
            next_mode[MB_THERM] = 1'b1;
        end
    end

    // Waveform update divider
    always_comb begin
        next_wtick = 1'b0;
        next_wdiv  = wdiv + 10'd1;
        if (srst || wdiv >= wlim) begin
            next_wdiv  = 10'd0;
            next_wtick = !srst;
        end
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_CMD;
            addr  <= 5'h00;
            left  <= 2'd0;
            shreg <= 16'h0000;
            mode  <= MODE_RESET;
            hold  <= 10'd0;
            dvld  <= 1'b0;
            dbyte <= 8'h00;
            srst  <= 1'b0;
            wdiv  <= 10'd0;
            wtick <= 1'b0;
        end else begin
            state <= next_state;
            addr  <= next_addr;
            left  <= next_left;
            shreg <= next_shreg;
            mode  <= next_mode;
            hold  <= next_hold;
            dvld  <= next_dvld;
            dbyte <= next_dbyte;
            srst  <= next_srst;
            wdiv  <= next_wdiv;
            wtick <= next_wtick;
        end
    end

    // Link outputs
    assign link.dev_vld  = dvld;
    assign link.dev_byte = dbyte;
    assign link.dev_busy = hold != 10'd0;

    // Mode fields, soft reset pulse and waveform tick to the metering logic
    assign bypass_highpass_o      = mode[MB_HPF_OFF];
    assign bypass_power_lowpass_o = mode[MB_LPF_OFF];
    assign pulse_out_off_o        = mode[MB_PULSE_OFF];
    assign dip_detect_off_o       = mode[MB_DIP_OFF];
    assign converters_powerdown_o = mode[MB_ADC_PD];
    assign thermal_conv_start_o   = mode[MB_THERM];
    assign soft_reset_o           = srst;
    assign halfcycle_accum_mode_o = mode[MB_HALFCYC];
    assign short_inputs_a_o       = mode[MB_SHORT_A];
    assign short_inputs_b_o       = mode[MB_SHORT_B];
    assign swap_inputs_o          = mode[MB_SWAP];
    assign wave_source_sel_o      = mode[MB_SRC_LSB +: 2];
    assign wave_len_o             = mode[MB_SRC_LSB +: 2] == SRC_DUAL
                                    ? WAVE_LEN_DUAL : WAVE_LEN_ONE;
    assign wave_tick_o            = wtick;
    assign factory_test_bit_o     = mode[MB_FACTORY];
    assign mode_config_o          = mode;

endmodule

// ===== rtl/mcm_pkg.sv
// Shared constants and helpers of the meter command and mode link
package mcm_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS  = 20;     // 50 MHz master clock
    localparam int unsigned HOLDOFF_NS     = 18000;  // Quiet time after reset
    localparam int unsigned HOLDOFF_CYC    =
        (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // Rounded up
    localparam int unsigned WAVE_DIV_BASE  = 128;    // Fastest divide code 00

    // Command byte layout
    localparam int unsigned CMD_ADDR_LSB   = 0;      // Register address field
    localparam int unsigned CMD_ADDR_W     = 5;      // Address width
    localparam int unsigned CMD_WRITE_BIT  = 7;      // One selects a write
    localparam logic [7:0]  CMD_RSVD_MASK  = 8'h60;  // Bits that must be zero

    // Mode register
    localparam logic [4:0]  MODE_ADDR      = 5'h06;   // Register address
    localparam logic [15:0] MODE_RESET     = 16'h000c; // Value after reset
    localparam int unsigned MB_HPF_OFF     = 0;
    localparam int unsigned MB_LPF_OFF     = 1;
    localparam int unsigned MB_PULSE_OFF   = 2;
    localparam int unsigned MB_DIP_OFF     = 3;
    localparam int unsigned MB_ADC_PD      = 4;
    localparam int unsigned MB_THERM       = 5;
    localparam int unsigned MB_SOFT_RST    = 6;
    localparam int unsigned MB_HALFCYC     = 7;
    localparam int unsigned MB_SHORT_A     = 8;
    localparam int unsigned MB_SHORT_B     = 9;
    localparam int unsigned MB_SWAP        = 10;
    localparam int unsigned MB_RATE_LSB    = 11;
    localparam int unsigned MB_SRC_LSB     = 13;
    localparam int unsigned MB_FACTORY     = 15;

    // Waveform sample lengths in bits
    localparam logic [5:0]  WAVE_LEN_DUAL  = 6'd40;
    localparam logic [5:0]  WAVE_LEN_ONE   = 6'd24;
    localparam logic [1:0]  SRC_DUAL       = 2'h1;

    // Host register offsets on Wishbone (byte addresses)
    localparam logic [3:0]  HR_CMD         = 4'h0;  // Write starts transfer
    localparam logic [3:0]  HR_WDATA       = 4'h4;  // Data to write
    localparam logic [3:0]  HR_RDATA       = 4'h8;  // Data read back
    localparam logic [3:0]  HR_STATUS      = 4'hc;  // Busy and holdoff
    localparam int unsigned HS_BUSY        = 0;
    localparam int unsigned HS_HOLD        = 1;

    // Data-phase length in bytes for a register address
    function automatic logic [1:0] mcm_reg_bytes(input logic [4:0] addr);
        mcm_reg_bytes = (addr == MODE_ADDR) ? 2'd2 : 2'd1;
    endfunction

endpackage

// ===== rtl/mcm_link_if.sv
// Byte-level link between the host controller and the meter device
`timescale 1ns/10ps
interface mcm_link_if (
    input wire logic clk_i   // Common clock of both ends
);
    logic       host_vld;     // Host byte valid, one cycle per byte, high on back-to-back cycles during a write
    logic [7:0] host_byte;    // Command or write data byte
    logic       rd_req;       // Host asks for the next read byte
    logic       dev_vld;      // Device read byte valid, one-cycle pulse
    logic [7:0] dev_byte;     // Read data byte
    logic       dev_busy;     // Device is in its post-reset quiet time

    // Device end
    modport dev (
        input  host_vld, host_byte, rd_req,
        output dev_vld, dev_byte, dev_busy
    );

    // Host end
    modport host (
        output host_vld, host_byte, rd_req,
        input  dev_vld, dev_byte, dev_busy
    );
endinterface

// ===== rtl/mcm_host.sv
// Host end: Wishbone-controlled command sender for the meter link
`timescale 1ns/10ps
module mcm_host
    import mcm_pkg::*;
(
    input  wire logic        clk_i,     // System clock
    input  wire logic        rst_i,     // Sync reset, high
    input  wire logic        wb_cyc_i,  // Wishbone cycle
    input  wire logic        wb_stb_i,  // Wishbone strobe
    input  wire logic        wb_we_i,   // Write enable
    input  wire logic [3:0]  wb_adr_i,  // Byte address
    input  wire logic [3:0]  wb_sel_i,  // Byte lanes
    input  wire logic [31:0] wb_dat_i,  // Write data
    output logic      [31:0] wb_dat_o,  // Read data
    output logic             wb_ack_o,  // Acknowledge
    mcm_link_if.host         link       // Link to device
);
    import mcm_pkg::*;

    // Transfer sequence
    typedef enum logic [2:0] {
        H_IDLE,    // Nothing running
        H_WR,      // Sending write bytes
        H_RDREQ,   // Asking for a read byte
        H_RDWAIT   // Waiting for the byte
    } mcm_host_state_t;

    mcm_host_state_t state, next_state;  // Sequence phase
    logic [7:0]  cmd,   next_cmd;        // Last command byte
    logic [15:0] wdata, next_wdata;      // Write data
    logic [15:0] rdata, next_rdata;      // Read data
    logic [1:0]  left,  next_left;       // Bytes still to move
    logic [9:0]  hold,  next_hold;       // Quiet-time counter
    logic        hvld,  next_hvld;       // Byte valid to device
    logic [7:0]  hbyte, next_hbyte;      // Byte to device
    logic        rreq,  next_rreq;       // Read request
    logic        ack,   next_ack;        // Bus acknowledge
    logic [31:0] dout,  next_dout;       // Bus read data
    logic        wb_go;                  // Bus access this cycle
    logic        busy;                   // Sequence running or quiet
    logic [15:0] tx;                     // Write word as sent

    assign wb_go = wb_cyc_i && wb_stb_i && !ack;
    assign busy  = state != H_IDLE || hold != 10'd0 || link.dev_busy;

    // Mode writes go out with the factory bit cleared
    always_comb begin
        tx = wdata;
        if (cmd[4:0] == MODE_ADDR) begin
            tx[MB_FACTORY] = 1'b0;
        end
    end

    // Bus decode and link sequencing
    always_comb begin
        next_state = state;
        next_cmd   = cmd;
        next_wdata = wdata;
        next_rdata = rdata;
        next_left  = left;
        next_hold  = hold == 10'd0 ? hold : hold - 10'd1;
        next_hvld  = 1'b0;
        next_hbyte = hbyte;
        next_rreq  = 1'b0;
        next_ack   = wb_go;
        next_dout  = 32'h0000_0000;
        // Register reads; unmapped reads return zero
        if (wb_go && !wb_we_i) begin
            unique case (wb_adr_i)
                HR_CMD:    next_dout = {24'h000000, cmd};
                HR_WDATA:  next_dout = {16'h0000, wdata};
                HR_RDATA:  next_dout = {16'h0000, rdata};
                HR_STATUS: next_dout = {30'h0, hold != 10'd0, busy};
                default:   next_dout = 32'h0000_0000;
            endcase
        end
        // Register writes
        if (wb_go && wb_we_i) begin
            if (wb_adr_i == HR_WDATA) begin
                if (wb_sel_i[0]) next_wdata[7:0]  = wb_dat_i[7:0];
                if (wb_sel_i[1]) next_wdata[15:8] = wb_dat_i[15:8];
            end
            // Command start, refused while busy
            if (wb_adr_i == HR_CMD && wb_sel_i[0] && !busy) begin
                next_cmd   = wb_dat_i[7:0] & ~CMD_RSVD_MASK;
                next_hvld  = 1'b1;
                next_hbyte = next_cmd;
                next_left  = mcm_reg_bytes(next_cmd[4:0]);
                next_state = next_cmd[CMD_WRITE_BIT] ? H_WR : H_RDREQ;
            end
        end
        unique case (state)
            H_IDLE: begin
            end
            H_WR: begin
                // Send bytes top first, back to back
                next_hvld  = 1'b1;
                next_hbyte = left == 2'd2 ? tx[15:8] : tx[7:0];
                next_left  = left - 2'd1;
                if (left == 2'd1) begin
                    next_state = H_IDLE;
                    if (cmd[4:0] == MODE_ADDR && tx[MB_SOFT_RST]) begin
                        next_hold = 10'(HOLDOFF_CYC + 1);
                    end
                end
            end
            H_RDREQ: begin
                next_rreq  = 1'b1;
                next_state = H_RDWAIT;
            end
            H_RDWAIT: begin
                // Collect byte, top first
                if (link.dev_vld) begin
                    next_rdata = {rdata[7:0], link.dev_byte};
                    next_left  = left - 2'd1;
                    next_state = left == 2'd1 ? H_IDLE : H_RDREQ;
                end
            end
            default: next_state = H_IDLE;
        endcase
        if (state == H_RDREQ && left == mcm_reg_bytes(cmd[4:0])) begin
            next_rdata = 16'h0000;
        end
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= H_IDLE;
            cmd   <= 8'h00;
            wdata <= 16'h0000;
            rdata <= 16'h0000;
            left  <= 2'd0;
            hold  <= 10'd0;
            hvld  <= 1'b0;
            hbyte <= 8'h00;
            rreq  <= 1'b0;
            ack   <= 1'b0;
            dout  <= 32'h0000_0000;
        end else begin
            state <= next_state;
            cmd   <= next_cmd;
            wdata <= next_wdata;
            rdata <= next_rdata;
            left  <= next_left;
            hold  <= next_hold;
            hvld  <= next_hvld;
            hbyte <= next_hbyte;
            rreq  <= next_rreq;
            ack   <= next_ack;
            dout  <= next_dout;
        end
    end

    assign wb_ack_o       = ack;
    assign wb_dat_o       = dout;
    assign link.host_vld  = hvld;
    assign link.host_byte = hbyte;
    assign link.rd_req    = rreq;

endmodule

// ===== testbench/mcm_checker.sv
// Link protocol checker between the host and device ends
`timescale 1ns/10ps
module mcm_checker
    import mcm_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       host_vld,
    input wire logic [7:0] host_byte,
    input wire logic       rd_req,
    input wire logic       dev_vld,
    input wire logic [7:0] dev_byte,
    input wire logic       dev_busy
);
    logic [1:0]  rem;       // Data units left in phase
    logic        wr;        // Phase is a write
    logic [10:0] bcnt;      // Quiet cycles so far
    logic [1:0]  next_rem;
    logic        next_wr;
    logic [10:0] next_bcnt;

    // Phase tracking from each command byte
    always_comb begin
        next_rem  = rem;
        next_wr   = wr;
        next_bcnt = dev_busy ? bcnt + 11'h1 : 11'h0;
        if (dev_busy) begin
            next_rem = 2'h0;
        end else if (host_vld && rem == 2'h0) begin
            next_wr  = host_byte[7];
            next_rem = (host_byte[4:0] == MODE_ADDR) ? 2'h2 : 2'h1;
        end else if (host_vld || dev_vld) begin
            next_rem = rem - 2'h1;
        end
    end

    // Register the tracking state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rem  <= 2'h0;
            wr   <= 1'b0;
            bcnt <= 11'h0;
        end else begin
            rem  <= next_rem;
            wr   <= next_wr;
            bcnt <= next_bcnt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_read_answer: assert property (rd_req && !dev_busy |=> dev_vld)
        else $error("read byte missing");
    chk_vld_cause: assert property (dev_vld |-> $past(rd_req))
        else $error("read byte without request");
    chk_vld_single: assert property (dev_vld |=> !dev_vld)
        else $error("read byte too long");
    chk_write_bytes: assert property (host_vld && rem == 2'h0 && host_byte[7] && host_byte[4:0] == MODE_ADDR |=> host_vld ##1 host_vld)
        else $error("mode write not two bytes");
    chk_rd_in_read: assert property (rd_req |-> rem != 2'h0 && !wr)
        else $error("read request outside read");
    chk_wr_in_write: assert property (host_vld && rem != 2'h0 |-> wr)
        else $error("data byte outside write");
    chk_cmd_reserved: assert property (host_vld && rem == 2'h0 |-> (host_byte & CMD_RSVD_MASK) == 8'h0)
        else $error("reserved command bits set");
    chk_quiet_host: assert property (dev_busy |-> !host_vld && !rd_req)
        else $error("transfer in quiet time");
    chk_quiet_len: assert property ($fell(dev_busy) |-> bcnt == 11'(HOLDOFF_CYC))
        else $error("quiet time length wrong");
    chk_quiet_cause: assert property ($rose(dev_busy) |-> wr)
        else $error("quiet time without write");
endmodule

// ===== testbench/test_meter_command_and_mode_regs.sv
// Testbench joining host and device ends over the link
`timescale 1ns/10ps
module test_meter_command_and_mode_regs;
    import mcm_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, temp_done = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [3:0]  adr = 4'h0, sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat;
    logic        hpf, lpf, pls, dip, pdn, thm, srst, half, sha, shb, swp;
    logic        tick, fac;
    logic [1:0]  src;
    logic [5:0]  wlen;
    logic [15:0] mode;
    int          failures = 0, comparisons = 0, polls, srst_cnt = 0;
    // Outputs laid out at their mode bit positions
    wire  [15:0] obs = {fac, src, 2'h0, swp, shb, sha, half, 1'b0, thm, pdn,
                        dip, pls, lpf, hpf};

    always #10 clk_i = ~clk_i;
    // Count soft reset pulses
    always @(posedge clk_i) if (srst === 1'b1) srst_cnt++;

    mcm_link_if u_mcm_link_if (.clk_i(clk_i));
    mcm_host u_mcm_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(u_mcm_link_if));
    mcm_dev u_mcm_dev (.clk_i(clk_i), .rst_i(rst_i), .link(u_mcm_link_if),
        .temp_done_i(temp_done), .bypass_highpass_o(hpf),
        .bypass_power_lowpass_o(lpf), .pulse_out_off_o(pls),
        .dip_detect_off_o(dip), .converters_powerdown_o(pdn),
        .thermal_conv_start_o(thm), .soft_reset_o(srst),
        .halfcycle_accum_mode_o(half), .short_inputs_a_o(sha),
        .short_inputs_b_o(shb), .swap_inputs_o(swp), .wave_source_sel_o(src),
        .wave_len_o(wlen), .wave_tick_o(tick), .factory_test_bit_o(fac),
        .mode_config_o(mode));
    mcm_checker u_mcm_checker (.clk_i(clk_i), .rst_i(rst_i),
        .host_vld(u_mcm_link_if.host_vld), .host_byte(u_mcm_link_if.host_byte),
        .rd_req(u_mcm_link_if.rd_req), .dev_vld(u_mcm_link_if.dev_vld),
        .dev_byte(u_mcm_link_if.dev_byte), .dev_busy(u_mcm_link_if.dev_busy));

    // Compare and count
    task automatic chk(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        // Ack and read data are taken at the same rising edge
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (ack !== 1'b1) chk(32'h0, 32'h1, "no ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // Command plus data, wait idle, return read data
    task automatic xfer(input logic [7:0] c, input logic [15:0] v,
                        output logic [31:0] q);
        polls = 0;
        wb(1'b1, HR_WDATA, {16'h0, v}, q);
        wb(1'b1, HR_CMD, {24'h0, c}, q);
        do begin
            wb(1'b0, HR_STATUS, 32'h0, q);
            polls++;
        end while (q[HS_BUSY] !== 1'b0 && polls < 600);
        wb(1'b0, HR_RDATA, 32'h0, q);
    endtask

    // Count cycles up to the next waveform tick
    task automatic wait_tick(output int m);
        m = 0;
        do begin
            @(negedge clk_i);
            m++;
        end while (tick !== 1'b1 && m < 3000);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        xfer(8'h06, 16'h0, q);
        chk(q, 32'h000c, "mode after reset");
    endtask

    task automatic t_bits();
        logic [31:0] q;
        logic [15:0] v;
        for (int b = 0; b < 16; b++) begin
            if (b inside {5, 6, 11, 12, 13, 14}) continue;
            v = 16'h1 << b;
            xfer(8'h86, v, q);
            if (b == 15) v = 16'h0;
            chk(32'(obs), 32'(v), "mode outputs");
            chk(32'(fac), 32'h0, "factory bit off");
            xfer(8'h06, 16'h0, q);
            chk(q, 32'(v), "mode readback");
        end
    endtask

    task automatic t_pattern();
        logic [31:0] q;
        xfer(8'he6, 16'h5a93, q);
        wb(1'b0, HR_CMD, 32'h0, q);
        chk(q & 32'hff, 32'h86, "command byte");
        xfer(8'h06, 16'h0, q);
        chk(q, 32'h5a93, "byte order");
        xfer(8'h85, 16'hffff, q);
        chk(32'(mode), 32'h5a93, "other address write");
        xfer(8'h05, 16'h0, q);
        chk(q, 32'h0, "other address read");
        wb(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
    endtask

    task automatic t_wave();
        logic [31:0] q;
        int          m;
        for (int c = 0; c < 4; c++) begin
            xfer(8'h86, {1'b0, c[1:0], c[1:0], 11'h0}, q);
            chk(32'(wlen), (c == 1) ? 32'd40 : 32'd24, "length");
            chk(32'(src), 32'(c), "source");
            wait_tick(m);
            wait_tick(m);
            chk(32'(m), 32'(WAVE_DIV_BASE << c), "rate");
        end
    endtask

    task automatic t_therm();
        logic [31:0] q;
        xfer(8'h86, 16'h0020, q);
        chk(32'(thm), 32'h1, "conversion start");
        @(posedge clk_i);
        temp_done <= 1'b1;
        @(posedge clk_i);
        temp_done <= 1'b0;
        @(negedge clk_i);
        chk(32'(thm), 32'h0, "conversion clear");
    endtask

    task automatic t_soft();
        logic [31:0] q;
        int          s0;
        s0 = srst_cnt;
        xfer(8'h86, 16'h0043, q);
        chk(32'(srst_cnt - s0), 32'h1, "soft pulse");
        chk(32'(polls > 250), 32'h1, "quiet time");
        chk(32'(mode), 32'h000c, "soft value");
        xfer(8'h06, 16'h0, q);
        chk(q, 32'h000c, "read after soft");
    endtask

    // Print counts and verdict, then stop
    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #600000;
        failures++;
        $display("MISMATCH %0t watchdog", $time);
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_bits();
        t_pattern();
        t_wave();
        t_therm();
        t_soft();
        end_sim();
    end
endmodule
